// >>> radio_control_register_bank_tb_top.sv
/* Testbench top for the radio control register bank.
 Host model drives the register port. */
`timescale 1ns/100ps
module radio_control_register_bank_tb_top;
    localparam int RC_CYC = 20;
    localparam logic [6:0] RA [12] = '{7'h01, 7'h05, 7'h06, 7'h53, 7'h54, 7'h55,
        7'h73, 7'h74, 7'h75, 7'h76, 7'h77, 7'h10};
    localparam logic [7:0] RV [12] = '{8'h13, 8'h00, 8'h01, 8'h45, 8'h00, 8'h04,
        8'h00, 8'h00, 8'h35, 8'hbb, 8'h80, 8'h00};
    logic sys_clk_i;
    logic rst_b_i;
    logic [6:0] a;
    logic wr;
    logic rd;
    logic [7:0] wd;
    logic [7:0] rdat;
    logic irq;
    logic vco;
    logic settle;
    logic ready;
    logic rc;
    logic fine;
    logic [7:0] d;
    bit fsk;
    bit txd;
    rcrb_pkg::rcrb_events_t events_i;
    rcrb_pkg::rcrb_synth_cfg_t cfg;
    int fail_count;
    int total_checks;
    int n;
    rcrb_host_model i_host (.sys_clk_i, .reg_addr_o(a), .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wd),
        .reg_rdata_i(rdat));
    // Version code 0x13 is arbitrary
    rcrb_register_bank #(.VERSION_CODE(5'h13), .RC_FULL_CAL_CYCLES(RC_CYC), .RC_FINE_PERIOD_CYCLES(50)) i_dut (
        .sys_clk_i, .rst_b_i, .reg_addr_i(a), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd),
        .reg_rdata_o(rdat), .events_i, .converter_calibration_done_i(1'h0), .deviation_word_i(9'h010),
        .fsk_enable_i(fsk), .tx_data_i(txd), .interrupt_request_low_o(irq), .vco_cal_active_o(vco),
        .pll_settling_o(settle), .pll_ready_o(ready), .rc_full_cal_o(rc), .rc_fine_cal_o(fine),
        .crystal_start_half_time_o(), .oscillator_calibration_mode_o(), .synth_cfg_o(cfg), .ds_carry_o());
    initial begin
        sys_clk_i = 1'h0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    // ==========================================
    // Helpers
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic rr(input logic [6:0] ad, input logic [7:0] e);
        i_host.rd(ad, d);
        chk("register", {8'h00, d}, {8'h00, e});
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wait_sig(input bit v, input string nm);
        n = 0;
        while ((v ? vco : ready) !== 1'h1 && n < 3000) begin
            cyc(1);
            n++;
        end
        chk(nm, 16'(v ? vco : ready), 16'h1);
    endtask
    task automatic pulse(input logic [15:0] e);
        @(posedge sys_clk_i);
        #1;
        events_i = e;
        cyc(1);
        events_i = '0;
        cyc(2);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #3000000;
        fail_count++;
        end_of_test();
    end
    // ==========================================
    // Main sequence
    initial begin
        fail_count = 0;
        total_checks = 0;
        rst_b_i = 1'h0;
        events_i = '0;
        cyc(3);
        rst_b_i = 1'h1;
        wait_sig(1'h1, "power-up cal");
        wait_sig(1'h0, "ready");
        for (int i = 0; i < 12; i++) rr(RA[i], RV[i]);
        i_host.wr(7'h01, 8'hff);
        rr(7'h01, 8'h13);
        i_host.wr(7'h75, 8'h1f);
        rr(7'h75, 8'h17);
        wait_sig(1'h0, "ready");
        chk("divide", 16'(cfg.divide_int), 16'h2f);
        chk("band", 16'(cfg.high_band), 16'h0);
        i_host.wr(7'h75, 8'h35);
        i_host.wr(7'h73, 8'h10);
        wait_sig(1'h0, "ready");
        chk("high band", 16'(cfg.high_band), 16'h1);
        chk("fraction", cfg.fraction, 16'hbb90);
        fsk = 1'h1;
        txd = 1'h1;
        i_host.wr(7'h05, 8'h04);
        chk("fsk up", cfg.fraction, 16'hbbb0);
        txd = 1'h0;
        pulse(16'h8000);
        chk("fsk down", cfg.fraction, 16'hbb70);
        chk("irq masked", 16'(irq), 16'h1);
        pulse(16'h0400);
        chk("irq", 16'(irq), 16'h0);
        rr(7'h03, 8'h84);
        cyc(2);
        chk("irq released", 16'(irq), 16'h1);
        rr(7'h03, 8'h80);
        pulse(16'h0001);
        chk("irq two", 16'(irq), 16'h0);
        rr(7'h04, 8'h01);
        rr(7'h04, 8'h00);
        i_host.wr(7'h55, 8'h0c);
        cyc(3);
        chk("rc cal", 16'(rc), 16'h1);
        cyc(RC_CYC + 5);
        rr(7'h55, 8'h04);
        i_host.wr(7'h55, 8'h14);
        n = 0;
        repeat (100) begin
            cyc(1);
            if (fine === 1'h1) n++;
        end
        chk("fine pulses", 16'(n), 16'h2);
        i_host.wr(7'h55, 8'h07);
        wait_sig(1'h1, "forced cal");
        wait_sig(1'h0, "ready");
        rr(7'h55, 8'h05);
        i_host.wr(7'h55, 8'h04);
        i_host.wr(7'h76, 8'hbb);
        wait_sig(1'h1, "retune cal");
        wait_sig(1'h0, "ready");
        end_of_test();
    end
endmodule
bind rcrb_register_bank rcrb_checker #(.RC_FULL_CAL_CYCLES(RC_FULL_CAL_CYCLES)) i_chk (.sys_clk_i, .rst_b_i,
    .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .events_i, .interrupt_request_low_o, .vco_cal_active_o,
    .pll_settling_o, .pll_ready_o, .rc_full_cal_o, .rc_fine_cal_o, .synth_cfg_o);

// >>> rcrb_checker_sva.sv
/* Checker for the radio control register bank.
 Bound to the bank's top module; sees only its ports. */
`timescale 1ns/100ps
module rcrb_checker #(
    parameter int RC_FULL_CAL_CYCLES = 20
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire rcrb_pkg::rcrb_events_t events_i,
    input wire logic interrupt_request_low_o,
    input wire logic vco_cal_active_o,
    input wire logic pll_settling_o,
    input wire logic pll_ready_o,
    input wire logic rc_full_cal_o,
    input wire logic rc_fine_cal_o,
    input wire rcrb_pkg::rcrb_synth_cfg_t synth_cfg_o
);
    // ==========================================
    // Length of the running RC calibration
    int rc_len;
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rc_len <= 0;
        end else begin
            rc_len <= rc_full_cal_o ? rc_len + 1 : 0;
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    // ==========================================
    // Properties
    chk_irq_cause: assert property ($fell(interrupt_request_low_o) |->
        $past(events_i != '0, 2) || $past(reg_wr_i, 2)) else $error("irq fell without a cause");
    chk_irq_release: assert property ($rose(interrupt_request_low_o) |->
        $past(reg_rd_i && reg_addr_i inside {7'h03, 7'h04}, 2) || $past(reg_wr_i, 2)) else $error("irq rose early");
    chk_version_top: assert property (reg_rd_i && reg_addr_i == 7'h01 |=> reg_rdata_o[7:5] == 3'h0)
        else $error("version upper bits set");
    chk_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
    chk_divide_range: assert property ($past(rst_b_i) |-> synth_cfg_o.divide_int inside {[6'h17:6'h30]})
        else $error("divide out of range");
    chk_rc_length: assert property ($fell(rc_full_cal_o) |-> rc_len == RC_FULL_CAL_CYCLES)
        else $error("rc cal length");
    chk_fine_pulse: assert property (rc_fine_cal_o |=> !rc_fine_cal_o [*8]) else $error("fine pulse too long");
    chk_ready_after: assert property ($rose(pll_ready_o) |-> $past(pll_settling_o))
        else $error("ready without settling");
    chk_freq_rearm: assert property (reg_wr_i && reg_addr_i inside {[7'h73:7'h77]} |-> ##[1:3] !pll_ready_o)
        else $error("no retune");
    chk_cal_then_settle: assert property ($fell(vco_cal_active_o) |-> pll_settling_o)
        else $error("no settle after cal");
    chk_vco_hold: assert property ($rose(vco_cal_active_o) |-> vco_cal_active_o [*8])
        else $error("vco cal too short");
endmodule

// >>> rcrb_host_model.sv
/* Host model: byte register port master for the bank.
 Assumes the testbench owns clock and reset. */
`timescale 1ns/100ps
module rcrb_host_model (
    input wire logic sys_clk_i,
    output logic [6:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i
);
    initial begin
        reg_addr_o = 7'h00;
        reg_wr_o = 1'h0;
        reg_rd_o = 1'h0;
        reg_wdata_o = 8'h00;
    end
    task automatic wr(input logic [6:0] ad, input logic [7:0] dt);
        @(posedge sys_clk_i);
        #1;
        reg_addr_o = ad;
        reg_wdata_o = dt;
        reg_wr_o = 1'h1;
        @(posedge sys_clk_i);
        #1;
        reg_wr_o = 1'h0;
        // Released data shows junk, not the last value
        reg_wdata_o = ~dt;
    endtask
    task automatic rd(input logic [6:0] ad, output logic [7:0] dt);
        @(posedge sys_clk_i);
        #1;
        reg_addr_o = ad;
        reg_rd_o = 1'h1;
        @(posedge sys_clk_i);
        #1;
        reg_rd_o = 1'h0;
        dt = reg_rdata_i;
    endtask
endmodule

// >>> rcrb_pkg.sv
/*
 Constants and carrier types for the radio control register bank.
 Assumes one 10 MHz clock; cycle figures derive from it.
*/
package rcrb_pkg;
    // ==========================================
    // Register offsets
    localparam logic [6:0] ADDR_VERSION = 7'h01;
    localparam logic [6:0] ADDR_STATUS_ONE = 7'h03;
    localparam logic [6:0] ADDR_STATUS_TWO = 7'h04;
    localparam logic [6:0] ADDR_ENABLE_ONE = 7'h05;
    localparam logic [6:0] ADDR_ENABLE_TWO = 7'h06;
    localparam logic [6:0] ADDR_PLL_TUNE = 7'h53;
    localparam logic [6:0] ADDR_RSVD_TIMING = 7'h54;
    localparam logic [6:0] ADDR_CAL_CTRL = 7'h55;
    localparam logic [6:0] ADDR_OFFSET_LOW = 7'h73;
    localparam logic [6:0] ADDR_OFFSET_HIGH = 7'h74;
    localparam logic [6:0] ADDR_BAND = 7'h75;
    localparam logic [6:0] ADDR_CARRIER_HIGH = 7'h76;
    localparam logic [6:0] ADDR_CARRIER_LOW = 7'h77;

    // ==========================================
    // Reset values and implemented bits
    localparam logic [7:0] RST_ENABLE_ONE = 8'h00;
    localparam logic [7:0] RST_ENABLE_TWO = 8'h01;
    localparam logic [7:0] RST_PLL_TUNE = 8'h45;
    localparam logic [7:0] RST_RSVD_TIMING = 8'h00;
    localparam logic [7:0] RST_CAL_CTRL = 8'h04;
    localparam logic [7:0] RST_OFFSET_LOW = 8'h00;
    localparam logic [1:0] RST_OFFSET_HIGH = 2'h0;
    localparam logic [7:0] RST_BAND = 8'h35;
    localparam logic [7:0] RST_CARRIER_HIGH = 8'hbb;
    localparam logic [7:0] RST_CARRIER_LOW = 8'h80;
    localparam logic [7:0] MASK_IRQ_ONE = 8'hec;
    localparam logic [7:0] MASK_IRQ_TWO = 8'h0f;
    localparam logic [7:0] MASK_BAND = 8'h7f;
    localparam logic [7:0] MASK_CAL_WR = 8'h57;

    // ==========================================
    // Field positions
    localparam int PLLTS_LSB = 3;
    localparam int CAL_XTAL_HALF = 6;
    localparam int CAL_ADC_DONE = 5;
    localparam int CAL_RC_FINE_EN = 4;
    localparam int CAL_RC_FORCE = 3;
    localparam int CAL_VCO_MODE = 2;
    localparam int CAL_VCO_FORCE = 1;
    localparam int CAL_VCO_SKIP = 0;
    localparam int BAND_SUB = 6;
    localparam int BAND_HIGH = 5;

    // ==========================================
    // Synthesizer arithmetic
    localparam logic [4:0] BAND_INT_MAX = 5'd23;
    localparam logic [5:0] BAND_INT_OFFSET = 6'd24;
    localparam logic [15:0] FRAC_MODULUS = 16'd64000;

    // ==========================================
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int RC_FULL_CAL_US = 2000;
    localparam int RC_FULL_CAL_CYC = RC_FULL_CAL_US * CYC_PER_US;
    localparam int RC_FINE_PERIOD_S = 30;
    localparam int RC_FINE_PERIOD_CYC = RC_FINE_PERIOD_S * CLK_HZ;
    // Default settle code of 8 units gives 200 us
    localparam int PLL_SETTLE_DEFAULT_US = 200;
    localparam int PLL_SETTLE_UNIT_CYC = PLL_SETTLE_DEFAULT_US * CYC_PER_US / 8;
    localparam int PLL_INIT_UNIT_US = 2;
    localparam int PLL_INIT_UNIT_CYC = PLL_INIT_UNIT_US * CYC_PER_US;
    localparam int VCO_CAL_US = 5;
    localparam int VCO_CAL_CYC = VCO_CAL_US * CYC_PER_US;

    // ==========================================
    // Types
    typedef enum logic [1:0] {
        TUNE_IDLE,
        TUNE_INIT_WAIT,
        TUNE_VCO_CAL,
        TUNE_SETTLE
    } rcrb_tune_state_t;

    typedef struct packed {
        logic [5:0] divide_int;
        logic [15:0] fraction;
        logic high_band;
        logic sub_band;
    } rcrb_synth_cfg_t;

    typedef struct packed {
        logic [7:0] status_one;
        logic [7:0] status_two;
    } rcrb_events_t;
endpackage

// >>> rcrb_register_bank.sv
/*
 Radio control register bank: interrupt status/enable, version, PLL timing,
 calibration control and synthesizer frequency words.
 Assumes a synchronous byte port and event pulses on sys_clk_i.
*/
// What this block does
// - Drive interrupt low on enabled active event
// - Interrupt stays low until status read
// - Only enabled events may assert interrupt
// - Status read clears its enabled bits
// - Disabled events still set readable status
// - Version read-only, five bits, upper zero
// - Auto VCO calibration on power-up, frequency change
// - VCO calibrate bit forces calibration
// - RC fine calibration every 30 s
// - RC calibrate bit forces 2 ms calibration
// - Settle-time field sets PLL settle wait
// - Initial-wait field delays before PLL settling
// - Modulo-64000 fractional accumulator at 10 MHz
// - Integer divide is band integer plus 24
// - Band integer above 23 stored as 23
// - Band select chooses high or low band
// - Fraction combines carrier, offset and deviation
// - FSK varies fraction with each data bit
`timescale 1ns/100ps
module rcrb_register_bank #(
    parameter logic [4:0] VERSION_CODE = 5'h0b, // Arbitrary value
    parameter int RC_FULL_CAL_CYCLES = rcrb_pkg::RC_FULL_CAL_CYC,
    parameter int RC_FINE_PERIOD_CYCLES = rcrb_pkg::RC_FINE_PERIOD_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire rcrb_pkg::rcrb_events_t events_i,
    input wire logic converter_calibration_done_i,
    input wire logic [8:0] deviation_word_i,
    input wire logic fsk_enable_i,
    input wire logic tx_data_i,
    output logic interrupt_request_low_o,
    output logic vco_cal_active_o,
    output logic pll_settling_o,
    output logic pll_ready_o,
    output logic rc_full_cal_o,
    output logic rc_fine_cal_o,
    output logic crystal_start_half_time_o,
    output logic oscillator_calibration_mode_o,
    output rcrb_pkg::rcrb_synth_cfg_t synth_cfg_o,
    output logic ds_carry_o
);
    // ==========================================
    // Register storage
    logic [7:0] status_one;
    logic [7:0] status_two;
    logic [7:0] enable_one;
    logic [7:0] enable_two;
    logic [7:0] pll_tune_time;
    logic [7:0] reserved_timing;
    logic [7:0] calibration_control;
    logic [7:0] offset_low;
    logic [1:0] offset_high;
    logic [7:0] band_select;
    logic [7:0] carrier_high;
    logic [7:0] carrier_low;

    logic wr_status_sel;
    logic rd_one;
    logic rd_two;
    logic freq_write;
    logic [4:0] band_int_select;

    assign rd_one = reg_rd_i && (reg_addr_i == rcrb_pkg::ADDR_STATUS_ONE);
    assign rd_two = reg_rd_i && (reg_addr_i == rcrb_pkg::ADDR_STATUS_TWO);
    assign wr_status_sel = reg_wr_i;
    assign freq_write = reg_wr_i && (reg_addr_i >= rcrb_pkg::ADDR_OFFSET_LOW)
        && (reg_addr_i <= rcrb_pkg::ADDR_CARRIER_LOW);
    assign band_int_select = band_select[4:0];

    // ==========================================
    // Interrupt status
    // Set wins over read-clear: no event lost
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_one <= 8'h00;
            status_two <= 8'h00;
        end else begin
            status_one <= ((status_one & ~(rd_one ? enable_one : 8'h00))
                | events_i.status_one) & rcrb_pkg::MASK_IRQ_ONE;
            status_two <= ((status_two & ~(rd_two ? enable_two : 8'h00))
                | events_i.status_two) & rcrb_pkg::MASK_IRQ_TWO;
        end
    end

    // Level follows enabled pending bits
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            interrupt_request_low_o <= 1'b1;
        end else begin
            interrupt_request_low_o <= ~(|(status_one & enable_one)
                | |(status_two & enable_two));
        end
    end

    // ==========================================
    // Plain read/write registers
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            enable_one <= rcrb_pkg::RST_ENABLE_ONE;
            enable_two <= rcrb_pkg::RST_ENABLE_TWO;
            pll_tune_time <= rcrb_pkg::RST_PLL_TUNE;
            reserved_timing <= rcrb_pkg::RST_RSVD_TIMING;
            offset_low <= rcrb_pkg::RST_OFFSET_LOW;
            offset_high <= rcrb_pkg::RST_OFFSET_HIGH;
            band_select <= rcrb_pkg::RST_BAND;
            carrier_high <= rcrb_pkg::RST_CARRIER_HIGH;
            carrier_low <= rcrb_pkg::RST_CARRIER_LOW;
        end else if (wr_status_sel) begin
            case (reg_addr_i)
                rcrb_pkg::ADDR_ENABLE_ONE: enable_one <= reg_wdata_i & rcrb_pkg::MASK_IRQ_ONE;
                rcrb_pkg::ADDR_ENABLE_TWO: enable_two <= reg_wdata_i & rcrb_pkg::MASK_IRQ_TWO;
                rcrb_pkg::ADDR_PLL_TUNE: pll_tune_time <= reg_wdata_i;
                rcrb_pkg::ADDR_RSVD_TIMING: reserved_timing <= reg_wdata_i;
                rcrb_pkg::ADDR_OFFSET_LOW: offset_low <= reg_wdata_i;
                rcrb_pkg::ADDR_OFFSET_HIGH: offset_high <= reg_wdata_i[1:0];
                rcrb_pkg::ADDR_BAND: begin
                    band_select <= reg_wdata_i & rcrb_pkg::MASK_BAND;
                    if (reg_wdata_i[4:0] > rcrb_pkg::BAND_INT_MAX) begin
                        band_select[4:0] <= rcrb_pkg::BAND_INT_MAX;
                    end
                end
                rcrb_pkg::ADDR_CARRIER_HIGH: carrier_high <= reg_wdata_i;
                rcrb_pkg::ADDR_CARRIER_LOW: carrier_low <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // ==========================================
    // Calibration control; triggers self-clear
    logic rc_busy;
    logic vco_cal_done;
    rcrb_pkg::rcrb_tune_state_t tune_state;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            calibration_control <= rcrb_pkg::RST_CAL_CTRL;
        end else begin
            if (reg_wr_i && (reg_addr_i == rcrb_pkg::ADDR_CAL_CTRL)) begin
                calibration_control[rcrb_pkg::CAL_XTAL_HALF] <= reg_wdata_i[rcrb_pkg::CAL_XTAL_HALF];
                calibration_control[rcrb_pkg::CAL_RC_FINE_EN] <= reg_wdata_i[rcrb_pkg::CAL_RC_FINE_EN];
                calibration_control[rcrb_pkg::CAL_VCO_MODE] <= reg_wdata_i[rcrb_pkg::CAL_VCO_MODE];
                calibration_control[rcrb_pkg::CAL_VCO_SKIP] <= reg_wdata_i[rcrb_pkg::CAL_VCO_SKIP];
                if (reg_wdata_i[rcrb_pkg::CAL_RC_FORCE]) begin
                    calibration_control[rcrb_pkg::CAL_RC_FORCE] <= 1'b1;
                end
                if (reg_wdata_i[rcrb_pkg::CAL_VCO_FORCE]) begin
                    calibration_control[rcrb_pkg::CAL_VCO_FORCE] <= 1'b1;
                end
            end else begin
                if (rc_busy && !rc_full_cal_o) begin
                    calibration_control[rcrb_pkg::CAL_RC_FORCE] <= 1'b0;
                end
                if (vco_cal_done) begin
                    calibration_control[rcrb_pkg::CAL_VCO_FORCE] <= 1'b0;
                end
            end
        end
    end

    assign crystal_start_half_time_o = calibration_control[rcrb_pkg::CAL_XTAL_HALF];
    assign oscillator_calibration_mode_o = calibration_control[rcrb_pkg::CAL_VCO_MODE];

    // ==========================================
    // RC oscillator calibration timers
    logic [31:0] rc_full_count;
    logic [31:0] rc_fine_count;

    // Busy lets the force bit clear only after the run
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rc_full_count <= 32'h0;
            rc_full_cal_o <= 1'b0;
            rc_busy <= 1'b0;
        end else if (rc_full_cal_o) begin
            rc_full_count <= rc_full_count + 32'h1;
            if (rc_full_count == 32'(RC_FULL_CAL_CYCLES - 1)) begin
                rc_full_cal_o <= 1'b0;
            end
        end else if (rc_busy) begin
            rc_busy <= 1'b0;
        end else if (calibration_control[rcrb_pkg::CAL_RC_FORCE]) begin
            rc_full_count <= 32'h0;
            rc_full_cal_o <= 1'b1;
            rc_busy <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rc_fine_count <= 32'h0;
            rc_fine_cal_o <= 1'b0;
        end else if (!calibration_control[rcrb_pkg::CAL_RC_FINE_EN]) begin
            rc_fine_count <= 32'h0;
            rc_fine_cal_o <= 1'b0;
        end else if (rc_fine_count == 32'(RC_FINE_PERIOD_CYCLES - 1)) begin
            rc_fine_count <= 32'h0;
            rc_fine_cal_o <= 1'b1;
        end else begin
            rc_fine_count <= rc_fine_count + 32'h1;
            rc_fine_cal_o <= 1'b0;
        end
    end

    // ==========================================
    // VCO calibration and PLL tune sequencer
    logic auto_cal_req;
    logic [15:0] tune_count;
    logic [15:0] init_wait_cycles;
    logic [15:0] settle_cycles;

    assign init_wait_cycles = 16'(pll_tune_time[2:0] * rcrb_pkg::PLL_INIT_UNIT_CYC);
    assign settle_cycles = 16'(pll_tune_time[7:rcrb_pkg::PLLTS_LSB] * rcrb_pkg::PLL_SETTLE_UNIT_CYC);
    assign vco_cal_done = (tune_state == rcrb_pkg::TUNE_VCO_CAL)
        && (tune_count >= 16'(rcrb_pkg::VCO_CAL_CYC - 1));

    // Set at reset for power-up; frequency writes re-arm
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            auto_cal_req <= 1'b1;
        end else if (freq_write) begin
            auto_cal_req <= 1'b1;
        end else if (tune_state == rcrb_pkg::TUNE_IDLE) begin
            auto_cal_req <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tune_state <= rcrb_pkg::TUNE_IDLE;
            tune_count <= 16'h0;
            pll_ready_o <= 1'b0;
        end else begin
            tune_count <= tune_count + 16'h1;
            case (tune_state)
                rcrb_pkg::TUNE_IDLE: begin
                    tune_count <= 16'h0;
                    if (auto_cal_req || calibration_control[rcrb_pkg::CAL_VCO_FORCE]) begin
                        tune_state <= rcrb_pkg::TUNE_INIT_WAIT;
                        pll_ready_o <= 1'b0;
                    end
                end
                rcrb_pkg::TUNE_INIT_WAIT: begin
                    if (tune_count >= init_wait_cycles) begin
                        tune_count <= 16'h0;
                        // Skip drops only automatic runs
                        if (calibration_control[rcrb_pkg::CAL_VCO_SKIP]
                            && !calibration_control[rcrb_pkg::CAL_VCO_FORCE]) begin
                            tune_state <= rcrb_pkg::TUNE_SETTLE;
                        end else begin
                            tune_state <= rcrb_pkg::TUNE_VCO_CAL;
                        end
                    end
                end
                rcrb_pkg::TUNE_VCO_CAL: begin
                    if (vco_cal_done) begin
                        tune_count <= 16'h0;
                        tune_state <= rcrb_pkg::TUNE_SETTLE;
                    end
                end
                rcrb_pkg::TUNE_SETTLE: begin
                    if (tune_count >= settle_cycles) begin
                        tune_state <= rcrb_pkg::TUNE_IDLE;
                        pll_ready_o <= 1'b1;
                    end
                end
                default: tune_state <= rcrb_pkg::TUNE_IDLE;
            endcase
        end
    end

    assign vco_cal_active_o = (tune_state == rcrb_pkg::TUNE_VCO_CAL);
    assign pll_settling_o = (tune_state == rcrb_pkg::TUNE_SETTLE);

    // ==========================================
    // Synthesizer divide words
    logic high_band;
    logic signed [18:0] frac_sum;
    logic signed [18:0] dev_term;
    logic [5:0] base_int;
    logic [5:0] next_int;
    logic [15:0] next_frac;
    logic [15:0] ds_accum;
    logic [16:0] accum_sum;

    assign high_band = band_select[rcrb_pkg::BAND_HIGH];
    assign base_int = {1'b0, band_int_select} + rcrb_pkg::BAND_INT_OFFSET;

    // Deviation is in fixed hertz steps; scale per band
    always_comb begin
        dev_term = 19'sd0;
        if (fsk_enable_i) begin
            dev_term = high_band ? 19'($signed({1'b0, deviation_word_i, 1'b0}))
                : 19'($signed({1'b0, deviation_word_i, 2'b00}));
            if (!tx_data_i) begin
                dev_term = -dev_term;
            end
        end
        frac_sum = $signed({3'b000, carrier_high, carrier_low})
            + 19'($signed({offset_high, offset_low})) + dev_term;
        next_int = base_int;
        next_frac = frac_sum[15:0];
        if (frac_sum < 19'sd0) begin
            next_int = base_int - 6'd1;
            next_frac = 16'(frac_sum + $signed({3'b000, rcrb_pkg::FRAC_MODULUS}));
        end else if (frac_sum >= $signed({3'b000, rcrb_pkg::FRAC_MODULUS})) begin
            next_int = base_int + 6'd1;
            next_frac = 16'(frac_sum - $signed({3'b000, rcrb_pkg::FRAC_MODULUS}));
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            synth_cfg_o <= '0;
        end else begin
            synth_cfg_o.divide_int <= next_int;
            synth_cfg_o.fraction <= next_frac;
            synth_cfg_o.high_band <= high_band;
            synth_cfg_o.sub_band <= band_select[rcrb_pkg::BAND_SUB];
        end
    end

    assign accum_sum = {1'b0, ds_accum} + {1'b0, synth_cfg_o.fraction};

    // First modulator stage; carry goes out on ds_carry_o, divide_int is not bumped here
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ds_accum <= 16'h0;
            ds_carry_o <= 1'b0;
        end else if (accum_sum >= {1'b0, rcrb_pkg::FRAC_MODULUS}) begin
            ds_accum <= 16'(accum_sum - {1'b0, rcrb_pkg::FRAC_MODULUS});
            ds_carry_o <= 1'b1;
        end else begin
            ds_accum <= accum_sum[15:0];
            ds_carry_o <= 1'b0;
        end
    end

    // ==========================================
    // Read data, taken before the read-clear
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                rcrb_pkg::ADDR_VERSION: reg_rdata_o <= {3'b000, VERSION_CODE};
                rcrb_pkg::ADDR_STATUS_ONE: reg_rdata_o <= status_one;
                rcrb_pkg::ADDR_STATUS_TWO: reg_rdata_o <= status_two;
                rcrb_pkg::ADDR_ENABLE_ONE: reg_rdata_o <= enable_one;
                rcrb_pkg::ADDR_ENABLE_TWO: reg_rdata_o <= enable_two;
                rcrb_pkg::ADDR_PLL_TUNE: reg_rdata_o <= pll_tune_time;
                rcrb_pkg::ADDR_RSVD_TIMING: reg_rdata_o <= reserved_timing;
                rcrb_pkg::ADDR_CAL_CTRL: begin
                    reg_rdata_o <= calibration_control & rcrb_pkg::MASK_CAL_WR;
                    reg_rdata_o[rcrb_pkg::CAL_ADC_DONE] <= converter_calibration_done_i;
                    reg_rdata_o[rcrb_pkg::CAL_RC_FORCE] <= calibration_control[rcrb_pkg::CAL_RC_FORCE];
                end
                rcrb_pkg::ADDR_OFFSET_LOW: reg_rdata_o <= offset_low;
                rcrb_pkg::ADDR_OFFSET_HIGH: reg_rdata_o <= {6'h00, offset_high};
                rcrb_pkg::ADDR_BAND: reg_rdata_o <= band_select;
                rcrb_pkg::ADDR_CARRIER_HIGH: reg_rdata_o <= carrier_high;
                rcrb_pkg::ADDR_CARRIER_LOW: reg_rdata_o <= carrier_low;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end
endmodule
